// >>> shared/maint_timing_pkg.sv
// constants, register layouts and reset values for channel maintenance timing
`default_nettype none
package maint_timing_pkg;
  localparam logic [7:0] OFS_POWER_STATE_TIMING = 8'h90;
  localparam logic [7:0] OFS_CALIBRATION_TIMING = 8'h94;
  localparam logic [7:0] OFS_IMPEDANCE_COMP_PARAMS = 8'h98;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ZQCS_UNIT_SHIFT = 4;
  localparam int unsigned ZQCL_UNIT_SHIFT = 5;

  // power_state_timing layout, bit 31 down to 0
  typedef struct packed {
    logic [7:0] rank_idle_count;
    logic [2:0] powerdown_exit_delay;
    logic [9:0] selfrefresh_exit_locked_delay;
    logic [7:0] selfrefresh_exit_delay;
    logic [2:0] min_clock_enable_pulse;
  } power_state_t;

  typedef struct packed {
    logic reserved;
    logic parallel_calibration_enable;
    logic periodic_calibration_enable;
    logic [20:0] calibration_interval;
    logic [2:0] short_calibration_delay;
    logic [4:0] long_calibration_delay;
  } calibration_t;

  typedef struct packed {
    logic [14:0] reserved;
    logic comp_enable;
    logic [5:0] comp_cmd_update_delay;
    logic [5:0] comp_block_length;
    logic [3:0] comp_interval;
  } comp_params_t;

  localparam logic [31:0] POWER_STATE_RESET = 32'h0000_0000;
  localparam logic PARALLEL_CAL_RESET = 1'b1;
  localparam logic PERIODIC_CAL_RESET = 1'b1;
  localparam logic [20:0] CAL_INTERVAL_RESET = 21'd16410;
  localparam logic [2:0] SHORT_CAL_RESET = 3'h4;
  localparam logic [4:0] LONG_CAL_RESET = 5'h00;
  localparam logic COMP_ENABLE_RESET = 1'b1;
  localparam logic [5:0] COMP_CMD_DELAY_RESET = 6'h02;
  localparam logic [5:0] COMP_LENGTH_RESET = 6'h09;
  localparam logic [3:0] COMP_INTERVAL_RESET = 4'h0;

  localparam calibration_t CALIBRATION_RESET = '{1'b0, PARALLEL_CAL_RESET,
      PERIODIC_CAL_RESET, CAL_INTERVAL_RESET, SHORT_CAL_RESET, LONG_CAL_RESET};
  localparam comp_params_t COMP_PARAMS_RESET = '{15'h0000, COMP_ENABLE_RESET,
      COMP_CMD_DELAY_RESET, COMP_LENGTH_RESET, COMP_INTERVAL_RESET};
endpackage
`default_nettype wire

// >>> hdl/maint_timing.sv
// channel power-state, calibration and compensation timing engine
`default_nettype none
module maint_timing
  import maint_timing_pkg::*;
#(
  parameter int unsigned NUM_RANKS = 2,
  parameter int unsigned MAINT_TICK_CYCLES = 8192
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration access
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // scheduler status
  input wire logic [NUM_RANKS-1:0] i_rank_pending,
  input wire logic i_sr_exit,
  input wire logic i_zqcl_req,
  // clock enable and power-down
  output logic o_cke,
  output logic o_pde_req,
  output logic o_pd_fast_exit,
  // command holds
  output logic o_cmd_hold,
  output logic o_dll_cmd_hold,
  // calibration commands
  output logic o_zqcs_req,
  output logic o_zqcl_req,
  output logic [NUM_RANKS-1:0] o_zq_rank_mask,
  // impedance compensation and maintenance tick
  output logic o_comp_block,
  output logic o_comp_cmd_update,
  output logic o_comp_data_update,
  output logic o_maint_tick
);
  localparam int unsigned TW = $clog2(MAINT_TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(MAINT_TICK_CYCLES - 1);

  function automatic logic [NUM_RANKS-1:0] lowest_bit(input logic [NUM_RANKS-1:0] x);
    lowest_bit = x & (~x + NUM_RANKS'(1));
  endfunction

  power_state_t pst_q;
  calibration_t cal_q;
  comp_params_t cmp_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic [7:0] idle_cnt_q [NUM_RANKS];
  logic all_idle;
  logic cke_q;
  logic [2:0] cke_age_q;
  logic cke_ok;
  logic [2:0] xp_cnt_q;
  logic [7:0] xs_cnt_q;
  logic [9:0] xsdll_cnt_q;
  logic [9:0] zq_wait_q;
  logic [20:0] zq_int_cnt_q;
  logic [NUM_RANKS-1:0] zqcs_pend_q;
  logic [NUM_RANKS-1:0] zqcl_pend_q;
  logic [3:0] comp_int_cnt_q;
  logic comp_pend_q;
  logic comp_active_q;
  logic [5:0] comp_pos_q;
  logic [5:0] comp_len;
  logic cmd_path_free;
  logic comp_go;
  logic zq_go;
  logic zq_long;
  logic [NUM_RANKS-1:0] zq_mask;
  logic maint_busy;
  logic pd_enter;
  logic pd_exit;

  // configuration registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pst_q <= power_state_t'(POWER_STATE_RESET);
      cal_q <= CALIBRATION_RESET;
      cmp_q <= COMP_PARAMS_RESET;
    end else if (i_cfg_wr) begin
      case (i_cfg_addr)
        OFS_POWER_STATE_TIMING: pst_q <= power_state_t'(i_cfg_wdata);
        OFS_CALIBRATION_TIMING: begin
          cal_q <= calibration_t'(i_cfg_wdata);
          cal_q.reserved <= 1'b0;
        end
        OFS_IMPEDANCE_COMP_PARAMS: begin
          cmp_q <= comp_params_t'(i_cfg_wdata);
          cmp_q.reserved <= 15'h0000;
        end
        default: ;
      endcase
    end
  end

  // read answer one cycle after the strobe, unmapped reads zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd) begin
        case (i_cfg_addr)
          OFS_POWER_STATE_TIMING: o_cfg_rdata <= pst_q;
          OFS_CALIBRATION_TIMING: o_cfg_rdata <= cal_q;
          OFS_IMPEDANCE_COMP_PARAMS: o_cfg_rdata <= cmp_q;
          default: o_cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // maintenance time base
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + TW'(1);
    end
  end
  assign o_maint_tick = tick_q;

  // per-rank idle counters, saturating
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int r = 0; r < NUM_RANKS; r++) begin
        idle_cnt_q[r] <= 8'h00;
      end
    end else begin
      for (int r = 0; r < NUM_RANKS; r++) begin
        if (i_rank_pending[r]) begin
          idle_cnt_q[r] <= 8'h00;
        end else if (idle_cnt_q[r] != 8'hFF) begin
          idle_cnt_q[r] <= idle_cnt_q[r] + 8'h01;
        end
      end
    end
  end

  // shared clock enable: every rank must be idle long enough
  always_comb begin
    all_idle = 1'b1;
    for (int r = 0; r < NUM_RANKS; r++) begin
      if (i_rank_pending[r] || (idle_cnt_q[r] < pst_q.rank_idle_count)) begin
        all_idle = 1'b0;
      end
    end
  end

  assign cke_ok = (cke_age_q >= pst_q.min_clock_enable_pulse);
  assign maint_busy = (|zqcs_pend_q) | (|zqcl_pend_q) | comp_pend_q | comp_active_q
                      | (zq_wait_q != 10'h000);
  assign pd_enter = cke_q & cke_ok & all_idle & ~maint_busy & (xp_cnt_q == 3'h0)
                    & (xs_cnt_q == 8'h00) & (xsdll_cnt_q == 10'h000) & ~i_sr_exit;
  assign pd_exit = ~cke_q & cke_ok & ((|i_rank_pending) | maint_busy | i_zqcl_req);

  // clock enable level and its age
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cke_q <= 1'b1;
      cke_age_q <= 3'h0;
      o_pde_req <= 1'b0;
    end else begin
      o_pde_req <= pd_enter;
      if (pd_enter | pd_exit) begin
        cke_q <= ~cke_q;
        cke_age_q <= 3'h1;
      end else if (cke_age_q != 3'h7) begin
        cke_age_q <= cke_age_q + 3'h1;
      end
    end
  end
  assign o_cke = cke_q;
  assign o_pd_fast_exit = 1'b1;

  // exit hold counters
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xp_cnt_q <= 3'h0;
      xs_cnt_q <= 8'h00;
      xsdll_cnt_q <= 10'h000;
    end else begin
      if (pd_exit) begin
        xp_cnt_q <= pst_q.powerdown_exit_delay;
      end else if (xp_cnt_q != 3'h0) begin
        xp_cnt_q <= xp_cnt_q - 3'h1;
      end
      if (i_sr_exit) begin
        xs_cnt_q <= pst_q.selfrefresh_exit_delay;
        xsdll_cnt_q <= pst_q.selfrefresh_exit_locked_delay;
      end else begin
        if (xs_cnt_q != 8'h00) begin
          xs_cnt_q <= xs_cnt_q - 8'h01;
        end
        if (xsdll_cnt_q != 10'h000) begin
          xsdll_cnt_q <= xsdll_cnt_q - 10'h001;
        end
      end
    end
  end

  // arbitration: compensation first, then long, then short calibration
  assign cmd_path_free = cke_q & (xp_cnt_q == 3'h0) & (xs_cnt_q == 8'h00)
                         & (zq_wait_q == 10'h000) & ~comp_active_q & ~pd_enter;
  assign comp_go = comp_pend_q & cmd_path_free;
  assign zq_long = |zqcl_pend_q;
  assign zq_go = cmd_path_free & ~comp_go & (zq_long | (|zqcs_pend_q));
  // parallel mode hits every pending rank, else one rank at a time
  assign zq_mask = cal_q.parallel_calibration_enable ?
                   (zq_long ? zqcl_pend_q : zqcs_pend_q) :
                   lowest_bit(zq_long ? zqcl_pend_q : zqcs_pend_q);

  // calibration scheduling and post-command wait
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zq_int_cnt_q <= 21'h000000;
      zqcs_pend_q <= '0;
      zqcl_pend_q <= '0;
      zq_wait_q <= 10'h000;
      o_zqcs_req <= 1'b0;
      o_zqcl_req <= 1'b0;
      o_zq_rank_mask <= '0;
    end else begin
      o_zqcs_req <= zq_go & ~zq_long;
      o_zqcl_req <= zq_go & zq_long;
      o_zq_rank_mask <= zq_go ? zq_mask : '0;
      if (zq_go) begin
        zq_wait_q <= zq_long ? {cal_q.long_calibration_delay, 5'h00}
                             : {3'h0, cal_q.short_calibration_delay, 4'h0};
      end else if (zq_wait_q != 10'h000) begin
        zq_wait_q <= zq_wait_q - 10'h001;
      end
      if (tick_q & cal_q.periodic_calibration_enable) begin
        if (zq_int_cnt_q + 21'h000001 >= cal_q.calibration_interval) begin
          zq_int_cnt_q <= 21'h000000;
        end else begin
          zq_int_cnt_q <= zq_int_cnt_q + 21'h000001;
        end
      end
      // a new due event wins over the clear of the issued ranks
      if (tick_q & cal_q.periodic_calibration_enable
          & (zq_int_cnt_q + 21'h000001 >= cal_q.calibration_interval)) begin
        zqcs_pend_q <= '1;
      end else if (!cal_q.periodic_calibration_enable) begin
        zqcs_pend_q <= '0;
      end else if (zq_go & ~zq_long) begin
        zqcs_pend_q <= zqcs_pend_q & ~zq_mask;
      end
      if (i_zqcl_req) begin
        zqcl_pend_q <= '1;
      end else if (zq_go & zq_long) begin
        zqcl_pend_q <= zqcl_pend_q & ~zq_mask;
      end
    end
  end

  // compensation interval and blocking window
  assign comp_len = (cmp_q.comp_block_length == 6'h00) ? 6'h01 : cmp_q.comp_block_length;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      comp_int_cnt_q <= 4'h0;
      comp_pend_q <= 1'b0;
      comp_active_q <= 1'b0;
      comp_pos_q <= 6'h00;
      o_comp_cmd_update <= 1'b0;
      o_comp_data_update <= 1'b0;
    end else begin
      if (tick_q & cmp_q.comp_enable) begin
        comp_int_cnt_q <= (comp_int_cnt_q >= cmp_q.comp_interval) ? 4'h0
                          : comp_int_cnt_q + 4'h1;
      end
      if (tick_q & cmp_q.comp_enable & (comp_int_cnt_q >= cmp_q.comp_interval)) begin
        comp_pend_q <= 1'b1;
      end else if (comp_go | ~cmp_q.comp_enable) begin
        comp_pend_q <= 1'b0;
      end
      o_comp_cmd_update <= comp_active_q & (comp_pos_q == cmp_q.comp_cmd_update_delay);
      o_comp_data_update <= comp_active_q & (comp_pos_q == comp_len - 6'h01);
      if (comp_go) begin
        comp_active_q <= 1'b1;
        comp_pos_q <= 6'h00;
      end else if (comp_active_q) begin
        if (comp_pos_q == comp_len - 6'h01) begin
          comp_active_q <= 1'b0;
        end
        comp_pos_q <= comp_pos_q + 6'h01;
      end
    end
  end
  assign o_comp_block = comp_active_q;

  assign o_cmd_hold = ~cke_q | (xp_cnt_q != 3'h0) | (xs_cnt_q != 8'h00)
                      | (zq_wait_q != 10'h000) | comp_active_q | zq_go | comp_go;
  assign o_dll_cmd_hold = o_cmd_hold | (xsdll_cnt_q != 10'h000);
endmodule
`default_nettype wire

// >>> sim/maint_timing_chk.sv
// assertion checker for the channel maintenance timing engine
`default_nettype none
module maint_timing_chk
  import maint_timing_pkg::*;
#(
  parameter int unsigned NUM_RANKS = 2,
  parameter int unsigned MAINT_TICK_CYCLES = 8192
) (
  // clock, reset, configuration
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  // status and outputs
  input wire logic [NUM_RANKS-1:0] i_rank_pending,
  input wire logic i_sr_exit,
  input wire logic o_cke,
  input wire logic o_pde_req,
  input wire logic o_pd_fast_exit,
  input wire logic o_cmd_hold,
  input wire logic o_dll_cmd_hold,
  input wire logic o_zqcs_req,
  input wire logic o_zqcl_req,
  input wire logic [NUM_RANKS-1:0] o_zq_rank_mask,
  input wire logic o_comp_block,
  input wire logic o_comp_cmd_update,
  input wire logic o_comp_data_update,
  input wire logic o_maint_tick
);
  power_state_t ps_q;
  calibration_t cal_q;
  comp_params_t cp_q;
  logic cke_q;
  logic seen_q;
  logic [7:0] run_q;
  logic [7:0] blk_q;
  logic [15:0] tick_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // shadow copies of the settings
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ps_q <= POWER_STATE_RESET;
      cal_q <= CALIBRATION_RESET;
      cp_q <= COMP_PARAMS_RESET;
    end else if (i_cfg_wr) begin
      if (i_cfg_addr == OFS_POWER_STATE_TIMING) ps_q <= i_cfg_wdata;
      if (i_cfg_addr == OFS_CALIBRATION_TIMING) cal_q <= {1'b0, i_cfg_wdata[30:0]};
      if (i_cfg_addr == OFS_IMPEDANCE_COMP_PARAMS) cp_q <= {15'h0000, i_cfg_wdata[16:0]};
    end
  end
  // level age, window length, tick spacing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cke_q <= 1'b1;
      run_q <= 8'hFF;
      blk_q <= 8'h00;
      tick_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      cke_q <= o_cke;
      run_q <= (o_cke != cke_q) ? 8'h01 : ((run_q == 8'hFF) ? run_q : run_q + 8'h01);
      blk_q <= o_comp_block ? blk_q + 8'h01 : 8'h00;
      tick_q <= o_maint_tick ? 16'h0000 : tick_q + 16'h0001;
      seen_q <= seen_q | o_maint_tick;
    end
  end
  property p_fast; o_pd_fast_exit == 1'b1; endproperty
  a_fast: assert property (p_fast) else $error("slow exit power-down selected");
  property p_pde; o_pde_req |-> !o_cke && $past(o_cke) && $past(i_rank_pending) == '0;
  endproperty
  a_pde: assert property (p_pde) else $error("power-down entry with busy rank");
  property p_cke;
    (o_cke != cke_q) |-> run_q >= ((ps_q.min_clock_enable_pulse == 3'h0) ? 8'h01
        : {5'h00, ps_q.min_clock_enable_pulse});
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable pulse too short");
  property p_xp; $rose(o_cke) && ps_q.powerdown_exit_delay >= 3'h3 |=> o_cmd_hold [*2];
  endproperty
  a_xp: assert property (p_xp) else $error("command allowed after power-down exit");
  property p_dll;
    $past(i_sr_exit) && ps_q.selfrefresh_exit_locked_delay >= 10'h008 |-> o_dll_cmd_hold [*8];
  endproperty
  a_dll: assert property (p_dll) else $error("locked-loop hold released early");
  property p_zqcs;
    o_zqcs_req && cal_q.short_calibration_delay != 3'h0 |=> o_cmd_hold [*8];
  endproperty
  a_zqcs: assert property (p_zqcs) else $error("command too soon after short cal");
  property p_mask; (o_zq_rank_mask != '0) == (o_zqcs_req || o_zqcl_req); endproperty
  a_mask: assert property (p_mask) else $error("rank mask without calibration pulse");
  property p_serial;
    $onehot0(o_zq_rank_mask) || cal_q.parallel_calibration_enable
        || $past(cal_q.parallel_calibration_enable);
  endproperty
  a_serial: assert property (p_serial) else $error("ranks calibrated together");
  property p_zqoff;
    !cal_q.periodic_calibration_enable && !$past(cal_q.periodic_calibration_enable)
        |-> !o_zqcs_req;
  endproperty
  a_zqoff: assert property (p_zqoff) else $error("short cal while disabled");
  property p_tick; o_maint_tick && seen_q |-> tick_q == 16'(MAINT_TICK_CYCLES - 1);
  endproperty
  a_tick: assert property (p_tick) else $error("maintenance tick spacing wrong");
  property p_blk;
    $fell(o_comp_block) |-> o_comp_data_update && blk_q == ((cp_q.comp_block_length == 6'h00)
        ? 8'h01 : {2'b00, cp_q.comp_block_length});
  endproperty
  a_blk: assert property (p_blk) else $error("compensation window length wrong");
  property p_cmdu; o_comp_cmd_update |-> blk_q == {2'b00, cp_q.comp_cmd_update_delay} + 8'h01;
  endproperty
  a_cmdu: assert property (p_cmdu) else $error("command update at wrong offset");
  c_pde: cover property (o_pde_req);
  c_zqcs: cover property (o_zqcs_req && !o_zq_rank_mask[0]);
  c_comp: cover property (o_comp_data_update);
endmodule
`default_nettype wire

// >>> sim/rank_model.sv
// far-side rank model: counts maintenance traffic seen by the ranks
`default_nettype none
module rank_model #(
  parameter int unsigned NUM_RANKS = 2
) (
  // controller outputs
  input wire logic i_clk,
  input wire logic i_cke,
  input wire logic i_zqcs,
  input wire logic i_zqcl,
  input wire logic i_comp_done,
  // counts
  output logic [15:0] o_zq_cnt = 16'h0000,
  output logic [15:0] o_comp_cnt = 16'h0000,
  output logic [15:0] o_pd_cnt = 16'h0000
);
  logic cke_q = 1'b1;
  always @(posedge i_clk) begin
    cke_q <= i_cke;
    if (i_zqcs || i_zqcl) o_zq_cnt <= o_zq_cnt + 16'h0001;
    if (i_comp_done) o_comp_cnt <= o_comp_cnt + 16'h0001;
    if (cke_q && !i_cke) o_pd_cnt <= o_pd_cnt + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> sim/maint_timing_tb_top.sv
// self-checking bench for the channel maintenance timing engine
`default_nettype none
module maint_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import maint_timing_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sr = 1'b0, zl = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] pend = 2'b11, mask;
  logic rvalid, cke, pde, hold, dhold, zqs, zqc, blk, dupd, cupd;
  logic [15:0] zq_cnt, comp_cnt, pd_cnt, c0, c1;
  int n_mismatch = 0, checks = 0, cyc = 0, t0;
  logic [7:0] ofs [4] = '{8'h90, 8'h94, 8'h98, 8'hA0};
  logic [31:0] rs [4] = '{32'h0000_0000, 32'h6040_1A80, 32'h0001_0890, 32'h0000_0000};
  logic [31:0] rw [4] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0001_FFFF, 32'h0000_0000};
  always #2 clk = ~clk;
  always @(posedge clk) cyc++;
  maint_timing #(.NUM_RANKS(2), .MAINT_TICK_CYCLES(16)) uut (.i_clk(clk), .i_rst(rst),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .i_rank_pending(pend), .i_sr_exit(sr), .i_zqcl_req(zl),
    .o_cke(cke), .o_pde_req(pde), .o_pd_fast_exit(), .o_cmd_hold(hold),
    .o_dll_cmd_hold(dhold), .o_zqcs_req(zqs), .o_zqcl_req(zqc), .o_zq_rank_mask(mask),
    .o_comp_block(blk), .o_comp_cmd_update(cupd), .o_comp_data_update(dupd), .o_maint_tick());
  rank_model #(.NUM_RANKS(2)) ranks (.i_clk(clk), .i_cke(cke), .i_zqcs(zqs), .i_zqcl(zqc),
    .i_comp_done(dupd), .o_zq_cnt(zq_cnt), .o_comp_cnt(comp_cnt), .o_pd_cnt(pd_cnt));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", exp, rdata);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return pde;
      1: return cke;
      2: return zqs && mask == 2'b01;
      3: return zqs;
      4: return zqc;
      5: return blk;
      7: return cupd;
      default: return !blk;
    endcase
  endfunction
  task automatic wait_on(input int s);
    int n;
    n = 0;
    while (sig(s) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        chk("wait", 32'(s), 32'hFFFF_FFFF);
        wrap_up();
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    foreach (ofs[i]) rreg(ofs[i], rs[i]);
    foreach (ofs[i]) begin
      wreg(ofs[i], 32'hFFFF_FFFF);
      rreg(ofs[i], rw[i]);
    end
    wreg(8'h90, 32'h0460_A053);
    wreg(8'h94, 32'h2000_1490);
    wreg(8'h98, 32'h0001_3DFF);
    $display("test registers done");
    pend = 2'b01;
    c0 = pd_cnt;
    repeat (100) @(negedge clk);
    chk("pd_one_busy", 32'(c0), 32'(pd_cnt));
    pend = 2'b00;
    wait_on(0);
    chk("cke_entry", 32'h0, {31'h0, cke});
    pend = 2'b01;
    wait_on(1);
    repeat (2) begin
      @(negedge clk);
      chk("pd_exit_hold", 32'h1, {31'h0, hold});
    end
    $display("test power-down done");
    sr = 1'b1;
    @(negedge clk);
    sr = 1'b0;
    repeat (8) @(negedge clk);
    chk("sr_hold", 32'h1, {31'h0, hold});
    repeat (10) @(negedge clk);
    chk("sr_dll_hold", 32'h1, {31'h0, dhold});
    $display("test self-refresh exit done");
    wait_on(2);
    t0 = cyc;
    @(negedge clk);
    wait_on(3);
    chk("zqcs_rank", 32'h2, {30'h0, mask});
    chk("zqcs_gap", 32'h1, 32'(cyc - t0 > 64));
    $display("test short calibration done");
    zl = 1'b1;
    @(negedge clk);
    zl = 1'b0;
    wait_on(4);
    chk("zqcl_rank", 32'h1, {30'h0, mask});
    t0 = cyc;
    @(negedge clk);
    wait_on(4);
    chk("zqcl_gap", 32'h1, 32'(cyc - t0 > 512));
    $display("test long calibration done");
    wait_on(6);
    wait_on(5);
    t0 = cyc;
    wait_on(7);
    chk("cmd_update_ofs", 32'd16, 32'(cyc - t0));
    wait_on(6);
    chk("comp_len", 32'd31, 32'(cyc - t0));
    chk("data_update", 32'h1, {31'h0, dupd});
    $display("test compensation done");
    wreg(8'h94, 32'h0000_1490);
    wreg(8'h98, 32'h0000_3DFF);
    repeat (100) @(negedge clk);
    c0 = zq_cnt;
    c1 = comp_cnt;
    repeat (700) @(negedge clk);
    chk("zq_off", 32'(c0), 32'(zq_cnt));
    chk("comp_off", 32'(c1), 32'(comp_cnt));
    $display("test disable done");
    wrap_up();
  end
endmodule
bind maint_timing maint_timing_chk #(.NUM_RANKS(NUM_RANKS),
  .MAINT_TICK_CYCLES(MAINT_TICK_CYCLES)) chk (.i_clk, .i_rst, .i_cfg_wr, .i_cfg_addr,
  .i_cfg_wdata, .i_rank_pending, .i_sr_exit, .o_cke, .o_pde_req, .o_pd_fast_exit,
  .o_cmd_hold, .o_dll_cmd_hold, .o_zqcs_req, .o_zqcl_req, .o_zq_rank_mask, .o_comp_block,
  .o_comp_cmd_update, .o_comp_data_update, .o_maint_tick);
`default_nettype wire
